/* File: src/xpc_pkg.sv */
// xpc_pkg: constants shared by the crosspoint controller files
// assumes: 125 MHz single clock, APB register access from software
package xpc_pkg;
    localparam int ADDR_WIDTH = 7;
    localparam int DATA_WIDTH = 6;
    localparam int SEL_WIDTH = 6;
    localparam int NUM_OUTPUTS = 34;
    localparam logic [5:0] BCAST_ADDR = 6'h3f;
    localparam logic [5:0] DISABLE_CODE = 6'h3f;
    localparam logic [3:0] LEVEL_RESET = 4'h7;
    localparam int LEVEL_BITS = 4;
    // apb register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_READ = 8'h10;
    localparam logic [7:0] REG_HOLD = 8'h14;
    // command codes in REG_CMD[1:0]
    localparam logic [1:0] CMD_WRITE = 2'h0;
    localparam logic [1:0] CMD_UPDATE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam logic [1:0] CMD_RESET = 2'h3;
    // field positions
    localparam int ADDR_BANK_BIT = 6;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    // default strobe width, in clock cycles
    localparam logic [7:0] HOLD_RESET = 8'h04;
    localparam logic [31:0] PERR_ZERO = 32'h0;
    typedef enum logic [2:0] {
        XPC_IDLE, XPC_SETUP, XPC_STROBE, XPC_RECOVER, XPC_RELEASE
    } xpc_state_type;
endpackage : xpc_pkg

/* File: src/xpc_timer.sv */
// xpc_timer: loadable down counter giving a one-cycle done pulse
// assumes: load is synchronous to the shared clock
module xpc_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] value_in,
    output logic done_out
);
    logic [WIDTH-1:0] count_q;
    logic run_q;
    wire logic last = run_q && (count_q <= WIDTH'(1));

    initial begin
        if (WIDTH < 2) $error("xpc_timer: WIDTH must be at least 2");
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            count_q <= '0;
            run_q <= 1'b0;
        end else if (load_in) begin
            count_q <= value_in;
            run_q <= 1'b1;
        end else if (run_q) begin
            count_q <= count_q - WIDTH'(1);
            run_q <= !last;
        end
    end

    // done ignores load: the sequencer reloads on done without a loop
    assign done_out = last;
endmodule : xpc_timer

/* File: src/xpc_ctrl.sv */
// xpc_ctrl: controller that drives the crosspoint switch control pins
// assumes: APB master from software, device pins sampled on REF_CLK_IN
// Functional notes
// R1: device holds 34 rows of two 6-bit latch ranks, one per output.
// R2: each write loads one first-rank row; many writes may precede update.
// R3: outputs follow second rank only; unchanged until an update.
// R4: readback drives the data bus with the addressed second-rank word.
// R5: reset clears second rank, disabling outputs, levels back to default.
// R6: with chip select inactive only reset acts.
// R7: chip select release keeps both ranks and the signal matrix intact.
// R8: all control inputs are level sensitive, held for a stable window.
// R9: six low address bits pick the output, binary.
// R10: top address bit picks connection bank (0) or level bank (1).
// R11: output address all ones broadcasts the write to every output.
// R12: connection bank data picks the input, msb first.
// R13: data all ones in the connection bank disables the output.
// R14: level bank uses four low data bits, upper two ignored.
// R15: reset level code is 0111, 16 mA, 2 mA per step.
// R16: controller releases its data drivers throughout readback.
// R17: low write strobe stores the data bus into the addressed row.
// R18: low update strobe copies all first-rank rows, address ignored.
// R19: readback wins over write; the two strobes never overlap here.
// R20: the controller never reads back at the broadcast address.
// R21: invalid output addresses leave latches unchanged.
module xpc_ctrl #(
    parameter int HOLD_WIDTH = 8
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // device address bus
    output logic [6:0] XP_ADDR_OUT,
    // device data bus, three signals per pin
    input wire logic [5:0] XP_DATA_IN,
    output logic [5:0] XP_DATA_OUT,
    output logic XP_DATA_OE_N_OUT,
    // device strobes, all active low
    output logic XP_CS_N_OUT,
    output logic XP_WRITE_N_OUT,
    output logic XP_UPDATE_N_OUT,
    output logic VIEW_BACK_N_OUT,
    output logic XP_RESET_N_OUT
);
    ////////////////////////////////////////////////////////////////////
    // parameter check
    initial begin
        if (HOLD_WIDTH < 3 || HOLD_WIDTH > 8)
            $error("xpc_ctrl: HOLD_WIDTH must be 3..8");
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    xpc_pkg::xpc_state_type state_q, state_d;
    logic [1:0] cmd_q;
    logic [6:0] addr_q;
    logic [5:0] data_q;
    logic [5:0] read_q;
    logic [HOLD_WIDTH-1:0] hold_q;
    logic err_q;
    logic load;
    logic done;

    ////////////////////////////////////////////////////////////////////
    // apb decode
    wire logic acc = PSEL_IN && PENABLE_IN;
    wire logic wr = acc && PWRITE_IN;
    wire logic busy = (state_q != xpc_pkg::XPC_IDLE);
    wire logic sel_cmd = (PADDR_IN == xpc_pkg::REG_CMD);
    wire logic sel_addr = (PADDR_IN == xpc_pkg::REG_ADDR);
    wire logic sel_data = (PADDR_IN == xpc_pkg::REG_DATA);
    wire logic sel_stat = (PADDR_IN == xpc_pkg::REG_STATUS);
    wire logic sel_read = (PADDR_IN == xpc_pkg::REG_READ);
    wire logic sel_hold = (PADDR_IN == xpc_pkg::REG_HOLD);
    wire logic mapped = sel_cmd || sel_addr || sel_data || sel_stat ||
        sel_read || sel_hold;
    wire logic [1:0] new_cmd = PWDATA_IN[1:0];
    wire logic [5:0] out_sel = addr_q[xpc_pkg::SEL_WIDTH-1:0];
    wire logic out_valid = (out_sel < 6'(xpc_pkg::NUM_OUTPUTS));
    wire logic out_bcast = (out_sel == xpc_pkg::BCAST_ADDR);
    // a write to an invalid output or a broadcast readback is refused
    wire logic bad_write = !out_valid && !out_bcast; // [R21] [R9]
    wire logic bad_read = !out_valid; // [R20]
    wire logic bad_cmd = (new_cmd == xpc_pkg::CMD_WRITE && bad_write) ||
        (new_cmd == xpc_pkg::CMD_READ && bad_read);
    // a command is started only while idle; busy writes get an error
    wire logic go = wr && sel_cmd && !busy && !bad_cmd;
    wire logic cfg_wr = wr && !busy;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = acc && (!mapped ||
        (PWRITE_IN && busy && (sel_cmd || sel_addr || sel_data ||
        sel_hold)) || (wr && sel_cmd && bad_cmd) ||
        (PWRITE_IN && (sel_stat || sel_read)));

    wire logic [31:0] rd_stat = {30'h0, err_q, busy};
    assign PRDATA_OUT = !acc || PWRITE_IN ? xpc_pkg::PERR_ZERO :
        sel_cmd ? {30'h0, cmd_q} :
        sel_addr ? {25'h0, addr_q} :
        sel_data ? {26'h0, data_q} :
        sel_stat ? rd_stat :
        sel_read ? {26'h0, read_q} :
        sel_hold ? {{(32 - HOLD_WIDTH){1'b0}}, hold_q} :
        xpc_pkg::PERR_ZERO;

    always_ff @(posedge REF_CLK_IN) begin
        if (!NRST_IN) begin
            cmd_q <= xpc_pkg::CMD_WRITE;
            addr_q <= '0;
            data_q <= '0;
            hold_q <= HOLD_WIDTH'(xpc_pkg::HOLD_RESET);
        end else begin
            if (go)
                cmd_q <= new_cmd;
            if (cfg_wr && sel_addr)
                addr_q <= PWDATA_IN[6:0];
            if (cfg_wr && sel_data)
                data_q <= PWDATA_IN[5:0];
            if (cfg_wr && sel_hold && PWDATA_IN[HOLD_WIDTH-1:0] > 1)
                hold_q <= PWDATA_IN[HOLD_WIDTH-1:0];
        end
    end

    // error flag: any access answered with PSLVERR sets it, a clean command clears it
    always_ff @(posedge REF_CLK_IN) begin
        if (!NRST_IN)
            err_q <= 1'b0;
        else if (acc && PSLVERR_OUT)
            err_q <= 1'b1;
        else if (go)
            err_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // strobe sequencer: setup, strobe held low, recover, release
    xpc_timer #(
        .WIDTH(HOLD_WIDTH)
    ) u_timer (
        .clk_in(REF_CLK_IN),
        .nrst_in(NRST_IN),
        .load_in(load),
        .value_in(hold_q),
        .done_out(done)
    );

    wire logic in_setup = (state_q == xpc_pkg::XPC_SETUP);
    wire logic in_strobe = (state_q == xpc_pkg::XPC_STROBE);
    wire logic in_recover = (state_q == xpc_pkg::XPC_RECOVER);

    always_comb begin
        state_d = state_q;
        load = 1'b0;
        case (state_q)
            xpc_pkg::XPC_IDLE: begin
                if (go) begin
                    state_d = xpc_pkg::XPC_SETUP;
                    load = 1'b1;
                end
            end
            xpc_pkg::XPC_SETUP: begin
                if (done) begin
                    state_d = xpc_pkg::XPC_STROBE;
                    load = 1'b1;
                end
            end
            xpc_pkg::XPC_STROBE: begin
                if (done) begin
                    state_d = xpc_pkg::XPC_RECOVER;
                    load = 1'b1;
                end
            end
            xpc_pkg::XPC_RECOVER: begin
                if (done)
                    state_d = xpc_pkg::XPC_RELEASE;
            end
            xpc_pkg::XPC_RELEASE:
                state_d = xpc_pkg::XPC_IDLE;
            default:
                state_d = xpc_pkg::XPC_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!NRST_IN)
            state_q <= xpc_pkg::XPC_IDLE;
        else
            state_q <= state_d;
    end

    // readback word sampled at the end of the strobe window
    always_ff @(posedge REF_CLK_IN) begin
        if (!NRST_IN)
            read_q <= '0;
        else if (in_strobe && done && cmd_q == xpc_pkg::CMD_READ)
            read_q <= XP_DATA_IN; // [R4]
    end

    ////////////////////////////////////////////////////////////////////
    // device pins, all registered
    wire logic active = in_setup || in_strobe || in_recover;
    // the accepting cycle already frames the pins for the new command
    wire logic [1:0] cmd_now = go ? new_cmd : cmd_q;
    wire logic is_wr = (cmd_now == xpc_pkg::CMD_WRITE);
    wire logic is_up = (cmd_now == xpc_pkg::CMD_UPDATE);
    wire logic is_rd = (cmd_now == xpc_pkg::CMD_READ);
    wire logic is_rst = (cmd_now == xpc_pkg::CMD_RESET);
    // next strobe levels: low only in the strobe phase
    wire logic next_strobe = (state_d == xpc_pkg::XPC_STROBE);
    wire logic next_active = (state_d == xpc_pkg::XPC_SETUP) ||
        next_strobe || (state_d == xpc_pkg::XPC_RECOVER);
    // level bank drops the upper two data bits
    wire logic lvl_bank = addr_q[xpc_pkg::ADDR_BANK_BIT]; // [R10]
    wire logic [5:0] wr_data = lvl_bank ?
        {2'h0, data_q[xpc_pkg::LEVEL_BITS-1:0]} : data_q; // [R14] [R12]
    logic oe_n_q;
    logic cs_n_q;

    always_ff @(posedge REF_CLK_IN) begin
        if (!NRST_IN) begin
            XP_ADDR_OUT <= '0;
            XP_DATA_OUT <= '0;
            oe_n_q <= 1'b1;
            cs_n_q <= 1'b1;
            XP_WRITE_N_OUT <= 1'b1;
            XP_UPDATE_N_OUT <= 1'b1;
            VIEW_BACK_N_OUT <= 1'b1;
            XP_RESET_N_OUT <= 1'b1;
        end else begin
            if (go) begin
                XP_ADDR_OUT <= PWDATA_IN[1:0] == xpc_pkg::CMD_UPDATE ?
                    XP_ADDR_OUT : addr_q; // [R18]
                XP_DATA_OUT <= wr_data;
            end
            // bus driven for writes only, released for all else
            oe_n_q <= !(next_active && is_wr); // [R16]
            // chip select only framing interface commands, not reset
            cs_n_q <= !(next_active && !is_rst); // [R6] [R7]
            XP_WRITE_N_OUT <= !(next_strobe && is_wr); // [R17] [R2] [R11]
            XP_UPDATE_N_OUT <= !(next_strobe && is_up); // [R18] [R3]
            VIEW_BACK_N_OUT <= !(next_strobe && is_rd); // [R4] [R19]
            XP_RESET_N_OUT <= !(next_strobe && is_rst); // [R5] [R15]
        end
    end

    // setup and recover phases keep address and data stable around
    // each level strobe [R8]
    assign XP_DATA_OE_N_OUT = oe_n_q;
    assign XP_CS_N_OUT = cs_n_q;
endmodule : xpc_ctrl

/* File: verif/xpc_dev.sv */
// xpc_dev: behavioural crosspoint control latches for the bench
// assumes: pins from xpc_ctrl; no pull on the shared data bus
module xpc_dev (
    // control pins
    input wire logic [6:0] addr_in,
    input wire logic [5:0] data_in,
    input wire logic oe_n_in,
    input wire logic cs_n_in,
    input wire logic we_n_in,
    input wire logic upd_n_in,
    input wire logic re_n_in,
    input wire logic rst_n_in,
    // resolved data bus
    output logic [5:0] bus_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] rank1 [2][34];
    logic [5:0] rank2 [2][34];
    logic [5:0] last = 6'h00;
    wire [5:0] row = addr_in[5:0];
    wire show = !cs_n_in && !re_n_in && row < 6'd34;
    wire wr = !cs_n_in && !we_n_in && re_n_in;
    // released bus shows the inverse of its last driven value
    assign bus_out = !oe_n_in ? data_in
        : show ? rank2[addr_in[6]][row] : ~last;
    always @(bus_out)
        if (!oe_n_in || show)
            last = bus_out;
    //////////////////////////////////////////////////////////////
    always @(addr_in, bus_out, cs_n_in, we_n_in, upd_n_in, re_n_in,
            rst_n_in) begin
        for (int b = 0; b < 2; b++) begin
            for (int r = 0; r < 34; r++) begin
                if (!rst_n_in) begin
                    rank1[b][r] = b ? 6'h07 : xpc_pkg::DISABLE_CODE;
                    rank2[b][r] = rank1[b][r];
                end else if (!cs_n_in) begin
                    if (wr && b == addr_in[6] && (row == r || &row))
                        rank1[b][r] = b ? {2'h0, bus_out[3:0]}
                            : bus_out;
                    if (!upd_n_in)
                        rank2[b][r] = rank1[b][r];
                end
            end
        end
    end
endmodule : xpc_dev

/* File: verif/xpc_ctrl_sva.sv */
// xpc_ctrl_sva: device pin protocol checks for the controller
// assumes: bound to xpc_ctrl, one clock, sync active-low reset
module xpc_ctrl_sva #(
    parameter int HOLD_WIDTH = 8
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    // device pins
    input wire logic [6:0] XP_ADDR_OUT,
    input wire logic [5:0] XP_DATA_OUT,
    input wire logic XP_DATA_OE_N_OUT,
    input wire logic XP_CS_N_OUT,
    input wire logic XP_WRITE_N_OUT,
    input wire logic XP_UPDATE_N_OUT,
    input wire logic VIEW_BACK_N_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!NRST_IN);
    wire wr = !XP_WRITE_N_OUT;
    //////////////////////////////////////////////////////////////
    sequence s_wr_hold;
        (wr && $stable(XP_ADDR_OUT) && $stable(XP_DATA_OUT)) [*2];
    endsequence
    sequence s_cs_held;
        !XP_CS_N_OUT [*2];
    endsequence
    property p_read_free;
        !VIEW_BACK_N_OUT |-> XP_DATA_OE_N_OUT;
    endproperty
    a_read_free: assert property (p_read_free)
        else $error("data bus driven during readback");
    property p_read_addr;
        !VIEW_BACK_N_OUT |-> XP_ADDR_OUT[5:0] < 6'd34;
    endproperty
    a_read_addr: assert property (p_read_addr)
        else $error("readback at invalid output");
    property p_wr_addr;
        wr |-> XP_ADDR_OUT[5:0] < 6'd34 || &XP_ADDR_OUT[5:0];
    endproperty
    a_wr_addr: assert property (p_wr_addr)
        else $error("write at invalid output");
    property p_wr_sel;
        wr |-> !XP_CS_N_OUT && !XP_DATA_OE_N_OUT && VIEW_BACK_N_OUT;
    endproperty
    a_wr_sel: assert property (p_wr_sel)
        else $error("write strobe without select or data");
    property p_upd_sel;
        !XP_UPDATE_N_OUT |-> !XP_CS_N_OUT && XP_WRITE_N_OUT;
    endproperty
    a_upd_sel: assert property (p_upd_sel)
        else $error("update strobe without select");
    property p_level;
        wr && XP_ADDR_OUT[6] |-> XP_DATA_OUT[5:4] == 2'b00;
    endproperty
    a_level: assert property (p_level)
        else $error("level write with upper bits set");
    property p_wr_pulse;
        $fell(XP_WRITE_N_OUT) |-> s_wr_hold ##[1:300] XP_WRITE_N_OUT;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe too short or unstable");
    property p_recover;
        $rose(XP_WRITE_N_OUT) |-> s_cs_held;
    endproperty
    a_recover: assert property (p_recover)
        else $error("select released too soon after write");
endmodule : xpc_ctrl_sva
bind xpc_ctrl xpc_ctrl_sva #(.HOLD_WIDTH(HOLD_WIDTH)) u_xpc_ctrl_sva (
    .REF_CLK_IN, .NRST_IN, .XP_ADDR_OUT, .XP_DATA_OUT,
    .XP_DATA_OE_N_OUT, .XP_CS_N_OUT, .XP_WRITE_N_OUT,
    .XP_UPDATE_N_OUT, .VIEW_BACK_N_OUT
);

/* File: verif/xpc_ctrl_test.sv */
// xpc_ctrl_test: self-checking bench for the crosspoint controller
// assumes: xpc_dev model on the device pins, apb driven from here
module xpc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, psel, pen, pwr, pready, pslverr;
    logic oe_n, cs_n, we_n, upd_n, re_n, rs_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [6:0] xa;
    logic [5:0] xd, xbus, r, r2, c, l;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [31:0] seed = 32'h0babba84;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    xpc_ctrl u_xpc_ctrl (.REF_CLK_IN(clk), .NRST_IN(nrst),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .XP_ADDR_OUT(xa),
        .XP_DATA_IN(xbus), .XP_DATA_OUT(xd), .XP_DATA_OE_N_OUT(oe_n),
        .XP_CS_N_OUT(cs_n), .XP_WRITE_N_OUT(we_n),
        .XP_UPDATE_N_OUT(upd_n), .VIEW_BACK_N_OUT(re_n),
        .XP_RESET_N_OUT(rs_n));
    xpc_dev u_xpc_dev (.addr_in(xa), .data_in(xd), .oe_n_in(oe_n),
        .cs_n_in(cs_n), .we_n_in(we_n), .upd_n_in(upd_n), .re_n_in(re_n),
        .rst_n_in(rs_n), .bus_out(xbus));
    //////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] x, g);
        num_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    function automatic logic [5:0] rnd(input logic [5:0] m);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return 6'(seed % m);
    endfunction : rnd
    // x holds {skip, pslverr, prdata} for the monitor
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [33:0] x);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back(x);
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic op(input logic [1:0] cm, input logic [6:0] a,
            input logic [5:0] d);
        apb(1'b1, xpc_pkg::REG_ADDR, {25'h0, a}, 34'h0);
        apb(1'b1, xpc_pkg::REG_DATA, {26'h0, d}, 34'h0);
        apb(1'b1, xpc_pkg::REG_CMD, {30'h0, cm}, 34'h0);
        q = 32'h1;
        while (q[0] !== 1'b0)
            apb(1'b0, xpc_pkg::REG_STATUS, 32'h0, {2'b10, 32'h0});
    endtask : op
    task automatic rb(input logic [6:0] a, input logic [5:0] x);
        op(xpc_pkg::CMD_READ, a, 6'h0);
        apb(1'b0, xpc_pkg::REG_READ, 32'h0, {28'h0, x});
    endtask : rb
    task automatic refuse(input logic [1:0] cm, input logic [6:0] a);
        apb(1'b1, xpc_pkg::REG_ADDR, {25'h0, a}, 34'h0);
        apb(1'b1, xpc_pkg::REG_CMD, {30'h0, cm}, {2'b01, 32'h0});
        apb(1'b0, xpc_pkg::REG_STATUS, 32'h0, 34'h2);
    endtask : refuse
    //////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1) begin
            e = exp_q.pop_front();
            if (!e[33]) begin
                chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
                if (!pwr)
                    chk("prdata", e[31:0], prdata);
            end
        end
    end
    initial begin
        {nrst, psel, pen, pwr, paddr, pwdata} = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, xpc_pkg::REG_HOLD, 32'h0, {26'h0, xpc_pkg::HOLD_RESET});
        apb(1'b0, xpc_pkg::REG_STATUS, 32'h0, 34'h0);
        apb(1'b0, 8'h18, 32'h0, {2'b01, 32'h0});
        apb(1'b1, xpc_pkg::REG_STATUS, 32'h1, {2'b01, 32'h0});
        apb(1'b1, xpc_pkg::REG_HOLD, 32'h2, 34'h0);
        apb(1'b1, xpc_pkg::REG_HOLD, 32'h1, 34'h0);
        apb(1'b0, xpc_pkg::REG_HOLD, 32'h0, 34'h2);
        op(xpc_pkg::CMD_RESET, 7'h0, 6'h0);
        r = rnd(6'd34);
        r2 = rnd(6'd34);
        c = rnd(6'd34);
        l = rnd(6'd63);
        rb({1'b0, r}, xpc_pkg::DISABLE_CODE);
        rb({1'b1, r}, {2'h0, xpc_pkg::LEVEL_RESET});
        op(xpc_pkg::CMD_WRITE, {1'b0, r}, c);
        op(xpc_pkg::CMD_WRITE, 7'h7f, l);
        rb({1'b0, r}, xpc_pkg::DISABLE_CODE);
        op(xpc_pkg::CMD_UPDATE, 7'h0, 6'h0);
        apb(1'b1, xpc_pkg::REG_CMD, {30'h0, xpc_pkg::CMD_UPDATE}, 34'h0);
        apb(1'b1, xpc_pkg::REG_DATA, 32'h0, {2'b01, 32'h0});
        q = 32'h1;
        while (q[0] !== 1'b0)
            apb(1'b0, xpc_pkg::REG_STATUS, 32'h0, {2'b10, 32'h0});
        apb(1'b0, xpc_pkg::REG_STATUS, 32'h0, 34'h2);
        rb({1'b0, r}, c);
        rb({1'b1, r2}, {2'h0, l[3:0]});
        refuse(xpc_pkg::CMD_WRITE, 7'h28);
        refuse(xpc_pkg::CMD_READ, 7'h3f);
        op(xpc_pkg::CMD_RESET, 7'h0, 6'h0);
        rb({1'b0, r}, xpc_pkg::DISABLE_CODE);
        rb({1'b1, r2}, {2'h0, xpc_pkg::LEVEL_RESET});
        close_out();
    end
endmodule : xpc_ctrl_test
